// ---- common/uesc_bank_if.sv ----
// Carrier between the register front end and the endpoint control bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface uesc_bank_if;
    logic wr_en;
    logic [1:0] wr_idx;
    logic [7:0] wr_data;
    logic [3:0] nak_out_set;
    logic [3:0] nak_in_set;
    logic bus_rst;
    logic [3:0][7:0] ctl;

    modport owner (
        input wr_en, wr_idx, wr_data, nak_out_set, nak_in_set, bus_rst,
        output ctl
    );
    modport user (
        output wr_en, wr_idx, wr_data, nak_out_set, nak_in_set, bus_rst,
        input ctl
    );
endinterface : uesc_bank_if

// ---- common/uesc_pkg.sv ----
// Constants and types for the endpoint select and configuration block.
// Assumes one 8-bit register port on the controller clock.
package uesc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] UESC_OFF_INDEX = 8'hc7;
    localparam logic [7:0] UESC_OFF_STATUS = 8'hce;
    localparam logic [7:0] UESC_OFF_FIFO = 8'hcf;
    localparam logic [7:0] UESC_OFF_CTL = 8'hd4;
    localparam logic [7:0] UESC_OFF_BCNT = 8'he2;
    localparam logic [7:0] UESC_OFF_EVT_STS = 8'hf0;
    localparam logic [7:0] UESC_OFF_EVT_CLR = 8'hf1;
    localparam logic [7:0] UESC_OFF_EVT_EN = 8'hf2;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int UESC_CTL_ON = 7;
    localparam int UESC_CTL_NAK_IEN = 6;
    localparam int UESC_CTL_NAK_OUT = 5;
    localparam int UESC_CTL_NAK_IN = 4;
    localparam int UESC_CTL_TOGGLE = 3;
    localparam int UESC_CTL_DIR = 2;
    localparam int UESC_CTL_KIND_LSB = 0;
    localparam logic [7:0] UESC_CTL_SW_MASK = 8'hc7;
    localparam logic [7:0] UESC_INDEX_MASK = 8'h03;

    // ************************************************************
    // Reset values and endpoint count
    // ************************************************************
    localparam logic [7:0] UESC_CTL_RST = 8'h00;
    localparam logic [1:0] UESC_INDEX_RST = 2'h0;
    localparam logic [3:0] UESC_EVT_RST = 4'h0;
    localparam int UESC_EP_COUNT = 4;

    typedef enum logic [1:0] {
        UESC_KIND_CONTROL = 2'b00,
        UESC_KIND_ISO = 2'b01,
        UESC_KIND_BULK = 2'b10,
        UESC_KIND_INTR = 2'b11
    } uesc_kind_t;

endpackage : uesc_pkg

// ---- core/uesc_ctl_bank.sv ----
// Per-endpoint control byte storage, one word per endpoint.
// Assumes writes and NAK set pulses come from the same clock domain.
`timescale 1ns/100ps
module uesc_ctl_bank
    import uesc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    uesc_bank_if.owner bank
);

    typedef struct packed {
        logic [3:0][7:0] ctl;
    } uesc_bank_st_t;

    uesc_bank_st_t st_r;
    uesc_bank_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < UESC_EP_COUNT; i++) begin
            if (bank.wr_en && bank.wr_idx == i[1:0]) begin
                // Flags take the written value, so firmware clears by writing zero
                st_nxt.ctl[i] = bank.wr_data & ~(8'h01 << UESC_CTL_TOGGLE);
            end
            // A NAK in the clearing cycle still lands: set wins
            if (bank.nak_out_set[i]) begin
                st_nxt.ctl[i][UESC_CTL_NAK_OUT] = 1'b1; // R8
            end
            if (bank.nak_in_set[i]) begin
                st_nxt.ctl[i][UESC_CTL_NAK_IN] = 1'b1; // R11
            end
        end
        // Bus reset leaves every endpoint off, endpoint 0 included
        if (bank.bus_rst) begin
            st_nxt.ctl = {UESC_EP_COUNT{UESC_CTL_RST}};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r <= {UESC_EP_COUNT{UESC_CTL_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bank.ctl = st_r.ctl;

endmodule : uesc_ctl_bank

// ---- core/uesc_top.sv ----
// Endpoint select and per-endpoint configuration for a full-speed USB device.
// Assumes the packet engine and firmware port share mclk; no pin inputs here.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps

// Operation
// R1 - Banked accesses go to indexed endpoint
// R2 - Index register upper six bits read zero
// R3 - Firmware writes no ones above index
// R4 - Control register shows the selected endpoint copy
// R5 - Enable bit lets endpoint join transfers
// R6 - Firmware enables endpoint 0 after resets
// R7 - NAK enable gates both NAK flags
// R8 - NAK answered to OUT sets flag
// R9 - OUT NAK flag interrupts only when enabled
// R10 - Firmware clears the OUT NAK flag
// R11 - NAK answered to IN sets flag
// R12 - Two-bit field selects transfer kind
module uesc_top
    import uesc_pkg::*;
#(
    parameter int EP_COUNT = UESC_EP_COUNT
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic bus_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic nak_out_evt,
    input wire logic nak_in_evt,
    input wire logic [1:0] evt_ep,
    input wire logic [3:0] toggle_in,
    input wire logic [7:0] status_rdata,
    input wire logic [7:0] fifo_rdata,
    input wire logic [7:0] bcnt_rdata,
    output logic [1:0] sel_ep,
    output logic status_wr,
    output logic [7:0] status_wdata,
    output logic fifo_wr,
    output logic fifo_rd,
    output logic [7:0] fifo_wdata,
    output logic [3:0] ep_on,
    output logic [3:0] ep_dir,
    output logic [7:0] ep_kind,
    output logic usb_irq
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    // The index field is two bits wide, so exactly four banks exist
    generate
        if (EP_COUNT != UESC_EP_COUNT) begin : g_bad_count
            $error("uesc_top: EP_COUNT must be 4");
        end
    endgenerate

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    function automatic logic [3:0] ep_onehot(input logic [1:0] ep, input logic en);
        ep_onehot = en ? (4'h1 << ep) : 4'h0;
    endfunction : ep_onehot

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [1:0] idx;
        logic [7:0] rdata;
        logic [3:0] evt_sts;
        logic [3:0] evt_en;
        logic irq;
        logic stat_wr;
        logic [7:0] stat_wdata;
        logic fwr;
        logic frd;
        logic [7:0] fwdata;
        logic [3:0] on;
        logic [3:0] dir;
        logic [7:0] kind;
    } uesc_top_st_t;

    uesc_top_st_t st_r;
    uesc_top_st_t st_nxt;

    uesc_bank_if bank_if ();

    uesc_ctl_bank u_bank (
        .mclk(mclk),
        .rst_b(rst_b),
        .bank(bank_if.owner)
    );

    // ************************************************************
    // Bank write path
    // ************************************************************
    logic ctl_wr_hit;
    assign ctl_wr_hit = reg_wr && hit(reg_addr, UESC_OFF_CTL);

    assign bank_if.wr_en = ctl_wr_hit;
    assign bank_if.wr_idx = st_r.idx; // R4
    assign bank_if.wr_data = reg_wdata & UESC_CTL_SW_MASK | (reg_wdata & 8'h30);
    assign bank_if.nak_out_set = ep_onehot(evt_ep, nak_out_evt); // R8
    assign bank_if.nak_in_set = ep_onehot(evt_ep, nak_in_evt); // R11
    assign bank_if.bus_rst = bus_rst;

    // ************************************************************
    // Per-endpoint decode
    // ************************************************************
    logic [3:0] nak_req;
    logic [3:0] on_nxt;
    logic [3:0] dir_nxt;
    logic [7:0] kind_nxt;
    logic [3:0][7:0] ctl_view;

    genvar g;
    generate
        for (g = 0; g < UESC_EP_COUNT; g++) begin : g_ep
            // Either flag raises the interrupt only behind the enable
            assign nak_req[g] = bank_if.ctl[g][UESC_CTL_NAK_IEN] & // R7
                (bank_if.ctl[g][UESC_CTL_NAK_OUT] | // R9
                 bank_if.ctl[g][UESC_CTL_NAK_IN]);
            assign on_nxt[g] = bank_if.ctl[g][UESC_CTL_ON]; // R5
            assign dir_nxt[g] = bank_if.ctl[g][UESC_CTL_DIR];
            assign kind_nxt[2*g +: 2] = bank_if.ctl[g][UESC_CTL_KIND_LSB +: 2]; // R12
            // The toggle bit is owned by the packet engine, read-only here
            assign ctl_view[g] = {bank_if.ctl[g][7:4], toggle_in[g], bank_if.ctl[g][2:0]};
        end
    endgenerate

    // ************************************************************
    // Register port and interrupt logic
    // ************************************************************
    always_comb begin
        logic [3:0] evt_set;
        evt_set = bank_if.nak_out_set | bank_if.nak_in_set;
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;
        st_nxt.stat_wr = 1'b0;
        st_nxt.fwr = 1'b0;
        st_nxt.frd = 1'b0;

        if (reg_wr) begin
            case (reg_addr)
                // Upper bits are dropped; firmware is expected to write zeros there
                UESC_OFF_INDEX: st_nxt.idx = reg_wdata[1:0]; // R3
                UESC_OFF_STATUS: begin
                    st_nxt.stat_wr = 1'b1; // R1
                    st_nxt.stat_wdata = reg_wdata;
                end
                UESC_OFF_FIFO: begin
                    st_nxt.fwr = 1'b1; // R1
                    st_nxt.fwdata = reg_wdata;
                end
                UESC_OFF_EVT_CLR: st_nxt.evt_sts = st_r.evt_sts & ~reg_wdata[3:0];
                UESC_OFF_EVT_EN: st_nxt.evt_en = reg_wdata[3:0];
                default: st_nxt.idx = st_r.idx;
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                UESC_OFF_INDEX: st_nxt.rdata = {6'h00, st_r.idx} & UESC_INDEX_MASK; // R2
                UESC_OFF_STATUS: st_nxt.rdata = status_rdata; // R1
                UESC_OFF_FIFO: begin
                    st_nxt.rdata = fifo_rdata; // R1
                    st_nxt.frd = 1'b1;
                end
                UESC_OFF_BCNT: st_nxt.rdata = bcnt_rdata; // R1
                UESC_OFF_CTL: st_nxt.rdata = ctl_view[st_r.idx]; // R4
                UESC_OFF_EVT_STS: st_nxt.rdata = {4'h0, st_r.evt_sts};
                UESC_OFF_EVT_EN: st_nxt.rdata = {4'h0, st_r.evt_en};
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // Sticky per-endpoint NAK events; a new event beats a same-cycle clear
        st_nxt.evt_sts = st_nxt.evt_sts | evt_set;
        if (bus_rst) begin
            st_nxt.idx = UESC_INDEX_RST;
        end

        st_nxt.on = on_nxt; // R5
        st_nxt.dir = dir_nxt;
        st_nxt.kind = kind_nxt; // R12
        // Registered copy keeps the output glitch-free at the cost of one cycle
        st_nxt.irq = (|nak_req) | (|(st_r.evt_sts & st_r.evt_en)); // R7
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Endpoint 0 stays off until firmware enables it after any reset
    assign reg_rdata = st_r.rdata;
    assign sel_ep = st_r.idx; // R1
    assign status_wr = st_r.stat_wr;
    assign status_wdata = st_r.stat_wdata;
    assign fifo_wr = st_r.fwr;
    assign fifo_rd = st_r.frd;
    assign fifo_wdata = st_r.fwdata;
    assign ep_on = st_r.on; // R6
    assign ep_dir = st_r.dir;
    assign ep_kind = st_r.kind;
    assign usb_irq = st_r.irq;

endmodule : uesc_top

// ---- tb/tb_top.sv ----
// Self-checking bench for the endpoint select and configuration block.
// Assumes the engine model and the port checker sit beside the design.
`timescale 1ns/100ps
module tb_top
    import uesc_pkg::*;
;
    logic mclk, rst_b, bus_rst, reg_wr, reg_rd, nak_out_evt, nak_in_evt, status_wr, fifo_wr, fifo_rd, usb_irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, status_rdata, fifo_rdata, bcnt_rdata;
    logic [7:0] status_wdata, fifo_wdata, ep_kind;
    logic [1:0] evt_ep, sel_ep;
    logic [3:0] toggle_in, ep_on, ep_dir;
    int err_count, checked;
    uesc_top #(.EP_COUNT(4)) i_dut (.mclk, .rst_b, .bus_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .nak_out_evt, .nak_in_evt, .evt_ep, .toggle_in, .status_rdata, .fifo_rdata,
        .bcnt_rdata, .sel_ep, .status_wr, .status_wdata, .fifo_wr, .fifo_rd, .fifo_wdata, .ep_on,
        .ep_dir, .ep_kind, .usb_irq);
    uesc_engine_model i_eng (.mclk, .sel_ep, .nak_out_evt, .nak_in_evt, .evt_ep, .toggle_in,
        .status_rdata, .fifo_rdata, .bcnt_rdata);
    always #5 mclk = ~mclk;
    // ****************
    // Bus and compare tasks
    // ****************
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        chk(what, reg_rdata, e);
    endtask : rdc
    // Two edges cover the flag and the registered interrupt
    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask : settle
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // ****************
    // Scenarios
    // ****************
    task automatic t_index;
        for (int i = 0; i < 4; i++) begin
            wr(UESC_OFF_INDEX, 8'(i));
            rdc(UESC_OFF_INDEX, 8'(i), "index");
            rdc(UESC_OFF_STATUS, {6'h04, 2'(i)}, "status");
            rdc(UESC_OFF_FIFO, {6'h08, 2'(i)}, "fifo");
            rdc(UESC_OFF_BCNT, {6'h0c, 2'(i)}, "count");
            chk("sel_ep", {6'h00, sel_ep}, 8'(i));
        end
        wr(UESC_OFF_STATUS, 8'h5a);
        wr(UESC_OFF_FIFO, 8'h3c);
        settle();
        chk("status_wdata", status_wdata, 8'h5a);
        chk("fifo_wdata", fifo_wdata, 8'h3c);
        rdc(8'h55, 8'h00, "unmapped");
        $display("index test done");
    endtask : t_index
    task automatic t_ctl;
        for (int i = 0; i < 4; i++) begin
            wr(UESC_OFF_INDEX, 8'(i));
            wr(UESC_OFF_CTL, 8'h80 | 8'(i));
        end
        settle();
        chk("ep_on", {4'h0, ep_on}, 8'h0f);
        chk("ep_kind", ep_kind, 8'he4);
        for (int i = 0; i < 4; i++) begin
            wr(UESC_OFF_INDEX, 8'(i));
            rdc(UESC_OFF_CTL, 8'h80 | 8'(i) | ((i % 2 == 0) ? 8'h08 : 8'h00), "ctl");
        end
        wr(UESC_OFF_INDEX, 8'h02);
        wr(UESC_OFF_CTL, 8'h04);
        settle();
        chk("ep_on", {4'h0, ep_on}, 8'h0b);
        chk("ep_dir", {4'h0, ep_dir}, 8'h04);
        $display("control test done");
    endtask : t_ctl
    task automatic t_nak;
        wr(UESC_OFF_INDEX, 8'h01);
        wr(UESC_OFF_CTL, 8'hc1);
        i_eng.nak(1'h1, 2'h1);
        settle();
        chk("irq out", {7'h00, usb_irq}, 8'h01);
        rdc(UESC_OFF_CTL, 8'he1, "out flag");
        wr(UESC_OFF_CTL, 8'hc1);
        settle();
        chk("irq cleared", {7'h00, usb_irq}, 8'h00);
        i_eng.nak(1'h0, 2'h1);
        settle();
        chk("irq in", {7'h00, usb_irq}, 8'h01);
        rdc(UESC_OFF_CTL, 8'hd1, "in flag");
        wr(UESC_OFF_CTL, 8'h81);
        wr(UESC_OFF_INDEX, 8'h03);
        i_eng.nak(1'h1, 2'h3);
        settle();
        chk("irq masked", {7'h00, usb_irq}, 8'h00);
        rdc(UESC_OFF_CTL, 8'ha3, "masked flag");
        rdc(UESC_OFF_EVT_STS, 8'h0a, "events");
        wr(UESC_OFF_EVT_EN, 8'h08);
        settle();
        chk("irq event", {7'h00, usb_irq}, 8'h01);
        wr(UESC_OFF_EVT_CLR, 8'h0a);
        settle();
        chk("irq event clr", {7'h00, usb_irq}, 8'h00);
        wr(UESC_OFF_CTL, 8'he3);
        settle();
        chk("irq enabled", {7'h00, usb_irq}, 8'h01);
        wr(UESC_OFF_CTL, 8'h83);
        $display("nak test done");
    endtask : t_nak
    task automatic t_bus;
        @(posedge mclk);
        bus_rst <= 1'h1;
        @(posedge mclk);
        bus_rst <= 1'h0;
        settle();
        chk("sel after bus", {6'h00, sel_ep}, 8'h00);
        chk("on after bus", {4'h0, ep_on}, 8'h00);
        rdc(UESC_OFF_CTL, 8'h08, "ctl after bus");
        wr(UESC_OFF_CTL, 8'h80);
        settle();
        chk("ep0 on", {4'h0, ep_on}, 8'h01);
        $display("bus reset test done");
    endtask : t_bus
    initial begin
        mclk = 1'h0;
        rst_b = 1'h0;
        bus_rst = 1'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (8) @(posedge mclk);
        rst_b <= 1'h1;
        t_index();
        t_ctl();
        t_nak();
        t_bus();
        report_and_stop();
    end
    initial begin
        #100us;
        err_count++;
        report_and_stop();
    end
endmodule : tb_top

// ---- tb/uesc_engine_model.sv ----
// Packet engine stand-in: per-endpoint data bytes and NAK answers.
// Assumes it shares mclk with the block; the bench calls nak().
`timescale 1ns/100ps
module uesc_engine_model (
    input wire logic mclk,
    input wire logic [1:0] sel_ep,
    output logic nak_out_evt,
    output logic nak_in_evt,
    output logic [1:0] evt_ep,
    output logic [3:0] toggle_in,
    output logic [7:0] status_rdata,
    output logic [7:0] fifo_rdata,
    output logic [7:0] bcnt_rdata
);
    // Each endpoint answers its own byte, so a misrouted access shows
    assign status_rdata = {6'h04, sel_ep};
    assign fifo_rdata = {6'h08, sel_ep};
    assign bcnt_rdata = {6'h0c, sel_ep};
    assign toggle_in = 4'h5;
    initial begin
        nak_out_evt = 1'h0;
        nak_in_evt = 1'h0;
        evt_ep = 2'h0;
    end
    task automatic nak(input logic out_dir, input logic [1:0] ep);
        @(posedge mclk);
        nak_out_evt <= out_dir;
        nak_in_evt <= !out_dir;
        evt_ep <= ep;
        @(posedge mclk);
        nak_out_evt <= 1'h0;
        nak_in_evt <= 1'h0;
        // Idle endpoint number is scrambled so it is never relied on
        evt_ep <= ~ep;
    endtask : nak
endmodule : uesc_engine_model

// ---- tb/uesc_monitor.sv ----
// Port checker for the endpoint select and configuration block.
// Assumes one clock, mclk, and a synchronous active-low reset.
`timescale 1ns/100ps
module uesc_monitor
    import uesc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic bus_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic nak_out_evt,
    input wire logic nak_in_evt,
    input wire logic [7:0] fifo_rdata,
    input wire logic [1:0] sel_ep,
    input wire logic status_wr,
    input wire logic [7:0] status_wdata,
    input wire logic fifo_wr,
    input wire logic fifo_rd,
    input wire logic [3:0] ep_on,
    input wire logic [7:0] ep_kind,
    input wire logic usb_irq
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    logic w_ctl;
    logic irq_cause;
    assign w_ctl = reg_wr && reg_addr == UESC_OFF_CTL && !bus_rst;
    assign irq_cause = nak_out_evt || nak_in_evt || reg_wr;
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_index_upper: assert property ($past(reg_rd) && $past(reg_addr) == UESC_OFF_INDEX
        |-> reg_rdata[7:2] == 6'h00) else $error("index upper bits not zero");
    chk_index_take: assert property (reg_wr && reg_addr == UESC_OFF_INDEX && !bus_rst
        |=> sel_ep == $past(reg_wdata[1:0])) else $error("index not taken");
    chk_status_route: assert property (reg_wr && reg_addr == UESC_OFF_STATUS
        |=> status_wr && status_wdata == $past(reg_wdata)) else $error("status write lost");
    chk_fifo_write: assert property (reg_wr && reg_addr == UESC_OFF_FIFO |=> fifo_wr)
        else $error("fifo write lost");
    chk_fifo_read: assert property (reg_rd && reg_addr == UESC_OFF_FIFO
        |=> fifo_rd && reg_rdata == $past(fifo_rdata)) else $error("fifo read wrong");
    chk_ctl_enable: assert property (w_ctl ##1 !bus_rst
        |=> ep_on[$past(sel_ep, 2)] == $past(reg_wdata[7], 2)) else $error("enable bit wrong");
    chk_ctl_kind: assert property (w_ctl ##1 !bus_rst
        |=> ep_kind[2*$past(sel_ep, 2) +: 2] == $past(reg_wdata[1:0], 2)) else $error("kind wrong");
    chk_bus_clear: assert property (bus_rst |=> sel_ep == 2'h0 ##1 ep_on == 4'h0)
        else $error("bus reset did not clear");
    chk_irq_cause: assert property ($rose(usb_irq) |-> $past(irq_cause, 2))
        else $error("interrupt rose without cause");
endmodule : uesc_monitor

bind uesc_top uesc_monitor i_mon (.mclk, .rst_b, .bus_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .nak_out_evt, .nak_in_evt, .fifo_rdata, .sel_ep, .status_wr, .status_wdata,
    .fifo_wr, .fifo_rd, .ep_on, .ep_kind, .usb_irq);
